// ==== design/wakeup_pkg.sv ====
// Purpose: shared constants and types for the wake-up and data-valid block
// Assumes: APB with 32-bit data, one word per register
// Notes:   printed offsets are not all multiples of four, so they are indices
package wakeup_pkg;

  // ----------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CONFIG   = 8'h00;  // configuration word
  localparam logic [7:0] IDX_ON_TIME  = 8'h04;  // on phase length
  localparam logic [7:0] IDX_OFF_TIME = 8'h05;  // off phase length
  localparam logic [7:0] IDX_TH_LOW   = 8'h06;  // rate_lower_threshold
  localparam logic [7:0] IDX_TH_UP    = 8'h07;  // rate_upper_threshold
  localparam logic [7:0] IDX_LEVEL    = 8'h08;  // level_threshold_and_source
  localparam logic [7:0] IDX_DIVIDER_RATIO   = 8'h0D;  // clock_divider_setup
  localparam logic [7:0] IDX_XTAL     = 8'h0E;  // crystal_setup
  localparam logic [7:0] IDX_BLOCKPD  = 8'h0F;  // block_power_down
  localparam logic [7:0] IDX_STATUS   = 8'h80;  // comparison_status
  localparam logic [7:0] IDX_ADC      = 8'h81;  // signal_level_readback

  // ----------------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------------
  localparam int CFG_POLL     = 1;   // self-polling select
  localparam int CFG_TIMER    = 2;   // timer select
  localparam int CFG_CNT_CONT = 5;   // window counter continuous
  localparam int CFG_ADC_CONT = 6;   // converter continuous
  localparam int CFG_INVERT   = 7;   // receive_invert
  localparam int CFG_DOUT     = 8;   // data output enable
  localparam int CFG_CLK_EN   = 9;   // clock always on

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_CONFIG   = 16'h0079;
  localparam logic [15:0] RST_ON_TIME  = 16'hFEC0;
  localparam logic [15:0] RST_OFF_TIME = 16'hF3C0;
  localparam logic [15:0] RST_TH       = 16'h0000;
  localparam logic [7:0]  RST_LEVEL    = 8'hFF;
  localparam logic [7:0]  RST_DIVIDER_RATIO   = 8'h08;
  localparam logic [7:0]  RST_XTAL     = 8'h01;
  localparam logic [15:0] RST_BLOCKPD  = 16'hFFFF;
  localparam logic [15:0] MASK_TH      = 16'h0FFF;
  localparam logic [7:0]  MASK_LEVEL   = 8'h7F;
  localparam logic [7:0]  MASK_DIVIDER_RATIO  = 8'h3F;
  localparam logic [7:0]  MASK_XTAL    = 8'h07;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int  CLK_MHZ       = 250;     // system clock rate
  localparam real TICK_US       = 31.25;   // one rc oscillator tick
  localparam real PULSE_US      = 15.0;    // low pulse on the wake pin
  localparam real SETTLE_MS     = 2.6;     // receiver settle before decision
  localparam int  SETTLE_RATES  = 3;       // extra data-rate periods
  localparam int  TICK_CYC      = int'(TICK_US * CLK_MHZ);
  localparam int  PULSE_CYC     = int'(PULSE_US * CLK_MHZ);
  localparam int  SETTLE_CYC    = int'(SETTLE_MS * 1000.0 * CLK_MHZ);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLAVE = 2'b00,
    MODE_TIMER = 2'b01,
    MODE_POLL  = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ON   = 2'b01,
    PH_OFF  = 2'b10
  } phase_t;

  typedef struct packed {
    logic [5:0] level;    // converter code
    logic       adcOff;   // converter powered down
    logic       source;   // converter source in use
  } level_in_t;

endpackage

// ==== design/wakeup_and_data_valid_logic.sv ====
// Purpose: wake-up timer, data-valid detector and register file
// Assumes: inputs synchronous to clk_sys; APB slave, zero wait states
// Notes:   slower rc time base is an enable pulse from a divider
// Function
// - two config bits select operating mode
// - slave mode: external pins control, wakeup idle
// - reset enters slave mode; software changes mode
// - self-polling cycles receiver from on/off registers
// - duty programmable in 31.25us tick steps
// - valid data gives 15us low pulse
// - one-shot pulse at 2.6ms plus three rates
// - continuous mode decides after every finished gate
// - clock output gated by on phase in polling mode unless enabled or wake pin low
// - timer mode pulses after on plus off
// - valid needs level above threshold and gate window match
// - status bits 7..5 rate versus thresholds
// - status bits 4..2 versus halved thresholds
// - status bits 1..0 level equal and above
// - converter readback: code, source, power state
// - upper threshold twelve bits, reset zero
// - data pin chosen by output and invert bits
// - data pin released in transmit with internal direction and wake pin low
// - block power-down bits reset to one
// - divider register: choice and ratio fields
// - crystal type bit, ramp only bipolar
// - converter source select defaults to level
// - on and off times at indices 4, 5
// - lower threshold twelve bits at index 6
// - timer select bit 2, polling bit 1
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module wakeup_and_data_valid_logic #(
  parameter int TICK_CYCLES   = wakeup_pkg::TICK_CYC,    // rc tick in clocks
  parameter int PULSE_CYCLES  = wakeup_pkg::PULSE_CYC,   // wake pulse length
  parameter int SETTLE_CYCLES = wakeup_pkg::SETTLE_CYC   // receiver settle time
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire wakeup_pkg::level_in_t levelIn,
  input  wire logic [11:0]           gateTime,
  input  wire logic                  gateDone,
  input  wire logic [15:0]           ratePeriod,
  input  wire logic                  powerdownWakePinIn,
  input  wire logic                  internalDirection,
  input  wire logic                  transmitOn,
  input  wire logic                  rxData,
  input  wire logic                  clkSource,
  output logic                       powerdownWakePinOut,
  output logic                       powerdownWakePinOe,
  output logic                       dataPinOut,
  output logic                       dataPinOe,
  output logic                       clkOut,
  output logic                       receiverOn,
  output logic [15:0]                blockPowerDown,
  output logic [7:0]                 clockDividerSetup,
  output logic [7:0]                 crystalSetup,
  output logic                       converterSource
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [15:0]       config_q;      // configuration word
  logic [15:0]       onTime_q;      // on phase ticks
  logic [15:0]       offTime_q;     // off phase ticks
  logic [15:0]       thLow_q;       // rate_lower_threshold
  logic [15:0]       thUp_q;        // rate_upper_threshold
  logic [7:0]        level_q;       // level threshold and source
  logic [7:0]        divider_ratio_q;      // clock divider setup
  logic [7:0]        xtal_q;        // crystal setup
  logic [15:0]       blockPd_q;     // block power down
  logic [7:0]        status_q;      // comparison status
  logic [7:0]        adc_q;         // converter readback
  wakeup_pkg::mode_t mode;          // decoded mode
  logic              wrEn;          // write strobe
  logic [7:0]        idx;           // register index

  assign idx  = paddr[9:2];
  assign wrEn = psel && penable && pwrite;

  // decode of the two mode bits; polling wins over timer
  always_comb begin
    if (config_q[wakeup_pkg::CFG_POLL]) begin
      mode = wakeup_pkg::MODE_POLL;
    end else if (config_q[wakeup_pkg::CFG_TIMER]) begin
      mode = wakeup_pkg::MODE_TIMER;
    end else begin
      mode = wakeup_pkg::MODE_SLAVE;
    end
  end

  // ----------------------------------------------------------------------
  // apb write side
  // ----------------------------------------------------------------------
  // writes land in the access phase; mode bits reset to slave
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      config_q  <= wakeup_pkg::RST_CONFIG;
      onTime_q  <= wakeup_pkg::RST_ON_TIME;
      offTime_q <= wakeup_pkg::RST_OFF_TIME;
      thLow_q   <= wakeup_pkg::RST_TH;
      thUp_q    <= wakeup_pkg::RST_TH;
      level_q   <= wakeup_pkg::RST_LEVEL;
      divider_ratio_q  <= wakeup_pkg::RST_DIVIDER_RATIO;
      xtal_q    <= wakeup_pkg::RST_XTAL;
      blockPd_q <= wakeup_pkg::RST_BLOCKPD;
    end else if (wrEn && paddr[31:10] == 22'h0) begin
      unique case (idx)
        wakeup_pkg::IDX_CONFIG:   config_q  <= pwdata[15:0];
        wakeup_pkg::IDX_ON_TIME:  onTime_q  <= pwdata[15:0];
        wakeup_pkg::IDX_OFF_TIME: offTime_q <= pwdata[15:0];
        wakeup_pkg::IDX_TH_LOW:   thLow_q   <= pwdata[15:0] & wakeup_pkg::MASK_TH;
        wakeup_pkg::IDX_TH_UP:    thUp_q    <= pwdata[15:0] & wakeup_pkg::MASK_TH;
        wakeup_pkg::IDX_LEVEL:    level_q   <= pwdata[7:0] | ~wakeup_pkg::MASK_LEVEL;
        wakeup_pkg::IDX_DIVIDER_RATIO:   divider_ratio_q  <= pwdata[7:0] & wakeup_pkg::MASK_DIVIDER_RATIO;
        wakeup_pkg::IDX_XTAL:     xtal_q    <= pwdata[7:0] & wakeup_pkg::MASK_XTAL;
        wakeup_pkg::IDX_BLOCKPD:  blockPd_q <= pwdata[15:0];
        default: ;  // read-only or unmapped: ignored
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // apb read side
  // ----------------------------------------------------------------------
  // single-cycle access; unmapped indices answer with an error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr[31:10] == 22'h0 ? idx : 8'hFF)
          wakeup_pkg::IDX_CONFIG:   prdata <= {16'h0000, config_q};
          wakeup_pkg::IDX_ON_TIME:  prdata <= {16'h0000, onTime_q};
          wakeup_pkg::IDX_OFF_TIME: prdata <= {16'h0000, offTime_q};
          wakeup_pkg::IDX_TH_LOW:   prdata <= {16'h0000, thLow_q};
          wakeup_pkg::IDX_TH_UP:    prdata <= {16'h0000, thUp_q};
          wakeup_pkg::IDX_LEVEL:    prdata <= {24'h000000, level_q};
          wakeup_pkg::IDX_DIVIDER_RATIO:   prdata <= {24'h000000, divider_ratio_q};
          wakeup_pkg::IDX_XTAL:     prdata <= {24'h000000, xtal_q};
          wakeup_pkg::IDX_BLOCKPD:  prdata <= {16'h0000, blockPd_q};
          wakeup_pkg::IDX_STATUS:   prdata <= {24'h000000, status_q};
          wakeup_pkg::IDX_ADC:      prdata <= {24'h000000, adc_q};
          default:                  pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // rc tick divider
  // ----------------------------------------------------------------------
  logic [15:0] tickCnt_q;  // clocks within one tick
  logic        tick;       // one-cycle 32 kHz enable

  assign tick = (tickCnt_q == 16'(TICK_CYCLES - 1));

  // free-running divider for the 31.25 us step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 16'h0000;
    end else if (tick) begin
      tickCnt_q <= 16'h0000;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // on/off phase timer
  // ----------------------------------------------------------------------
  wakeup_pkg::phase_t phase_q;    // current phase
  logic [15:0]        phaseCnt_q; // ticks spent in phase
  logic               onStart;    // first cycle of an on phase
  logic               cycleEnd;   // on plus off elapsed

  // zero-length phases still last until the next tick, the same as a length of one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q    <= wakeup_pkg::PH_IDLE;
      phaseCnt_q <= 16'h0000;
      onStart    <= 1'b0;
      cycleEnd   <= 1'b0;
    end else begin
      onStart  <= 1'b0;
      cycleEnd <= 1'b0;
      if (mode == wakeup_pkg::MODE_SLAVE) begin
        phase_q    <= wakeup_pkg::PH_IDLE;
        phaseCnt_q <= 16'h0000;
      end else begin
        unique case (phase_q)
          wakeup_pkg::PH_IDLE: begin
            phase_q    <= wakeup_pkg::PH_ON;
            phaseCnt_q <= 16'h0000;
            onStart    <= 1'b1;
          end
          wakeup_pkg::PH_ON: begin
            if (tick) begin
              if (phaseCnt_q + 16'h0001 >= onTime_q) begin
                phase_q    <= wakeup_pkg::PH_OFF;
                phaseCnt_q <= 16'h0000;
              end else begin
                phaseCnt_q <= phaseCnt_q + 16'h0001;
              end
            end
          end
          wakeup_pkg::PH_OFF: begin
            if (tick) begin
              if (phaseCnt_q + 16'h0001 >= offTime_q) begin
                phase_q    <= wakeup_pkg::PH_ON;
                phaseCnt_q <= 16'h0000;
                onStart    <= 1'b1;
                cycleEnd   <= 1'b1;
              end else begin
                phaseCnt_q <= phaseCnt_q + 16'h0001;
              end
            end
          end
          default: phase_q <= wakeup_pkg::PH_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // comparisons and status
  // ----------------------------------------------------------------------
  logic [11:0] halfLow;   // halved lower threshold
  logic [11:0] halfUp;    // halved upper threshold
  logic [7:0]  statusD;   // fresh comparison result
  logic        valid;     // data valid decision

  assign halfLow = {1'b0, thLow_q[11:1]};
  assign halfUp  = {1'b0, thUp_q[11:1]};

  // window and level comparisons
  always_comb begin
    statusD[7] = gateTime < thLow_q[11:0];
    statusD[6] = gateTime > thLow_q[11:0] && gateTime < thUp_q[11:0];
    statusD[5] = gateTime > thUp_q[11:0];
    statusD[4] = gateTime < halfLow;
    statusD[3] = gateTime > halfLow && gateTime < halfUp;
    statusD[2] = gateTime > halfUp;
    statusD[1] = levelIn.level == level_q[5:0];
    statusD[0] = levelIn.level > level_q[5:0];
  end

  assign valid = statusD[0] && statusD[6];

  // status refreshes on each finished gate; readback follows converter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
      adc_q    <= 8'h00;
    end else begin
      adc_q <= {levelIn.adcOff, levelIn.source, levelIn.level};
      if (gateDone) begin
        status_q <= statusD;
      end
    end
  end

  // ----------------------------------------------------------------------
  // decision timing and wake pulse
  // ----------------------------------------------------------------------
  logic [31:0] settleCnt_q;  // clocks since on phase start
  logic        armed_q;      // one-shot decision pending
  logic        decide;       // decision moment
  logic [15:0] pulseCnt_q;   // remaining pulse clocks
  logic [31:0] settleTotal;  // settle plus three rate periods
  logic        contMode;     // both converter and counter continuous

  assign settleTotal = 32'(SETTLE_CYCLES) + 32'(wakeup_pkg::SETTLE_RATES) * {16'h0000, ratePeriod};
  assign contMode = config_q[wakeup_pkg::CFG_ADC_CONT] && config_q[wakeup_pkg::CFG_CNT_CONT];

  // one-shot: single decision per on phase; continuous: each gate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_q <= 32'h0000_0000;
      armed_q     <= 1'b0;
    end else if (mode != wakeup_pkg::MODE_POLL || phase_q != wakeup_pkg::PH_ON) begin
      armed_q <= 1'b0;
    end else if (onStart) begin
      settleCnt_q <= 32'h0000_0000;
      armed_q     <= 1'b1;
    end else if (armed_q) begin
      if (settleCnt_q < settleTotal) begin
        settleCnt_q <= settleCnt_q + 32'h0000_0001;
      end else if (!contMode) begin
        armed_q <= 1'b0;  // one-shot decision taken in this cycle
      end
    end
  end

  always_comb begin
    if (mode == wakeup_pkg::MODE_POLL && armed_q && settleCnt_q >= settleTotal) begin
      decide = contMode ? gateDone : 1'b1;
    end else begin
      decide = 1'b0;
    end
  end

  // low pulse on the wake pin for valid data or timer interrupt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulseCnt_q          <= 16'h0000;
      powerdownWakePinOut <= 1'b1;
      powerdownWakePinOe  <= 1'b0;
    end else begin
      if ((decide && valid) ||
          (mode == wakeup_pkg::MODE_TIMER && cycleEnd)) begin
        pulseCnt_q <= 16'(PULSE_CYCLES);
      end else if (pulseCnt_q != 16'h0000) begin
        pulseCnt_q <= pulseCnt_q - 16'h0001;
      end
      powerdownWakePinOut <= 1'b0;
      powerdownWakePinOe  <= (pulseCnt_q != 16'h0000) && mode != wakeup_pkg::MODE_SLAVE;
    end
  end

  // ----------------------------------------------------------------------
  // pins and outputs
  // ----------------------------------------------------------------------
  // clock gating, receiver enable, data pin and register echoes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkOut            <= 1'b0;
      receiverOn        <= 1'b0;
      dataPinOut        <= 1'b0;
      dataPinOe         <= 1'b0;
      blockPowerDown    <= wakeup_pkg::RST_BLOCKPD;
      clockDividerSetup <= wakeup_pkg::RST_DIVIDER_RATIO;
      crystalSetup      <= wakeup_pkg::RST_XTAL;
      converterSource   <= 1'b1;
    end else begin
      if (mode == wakeup_pkg::MODE_POLL && !config_q[wakeup_pkg::CFG_CLK_EN]
          && powerdownWakePinIn) begin
        clkOut <= clkSource && phase_q == wakeup_pkg::PH_ON;
      end else begin
        clkOut <= clkSource;
      end
      receiverOn <= mode == wakeup_pkg::MODE_POLL && phase_q == wakeup_pkg::PH_ON;
      if (internalDirection && transmitOn && !powerdownWakePinIn) begin
        dataPinOut <= 1'b0;
        dataPinOe  <= 1'b0;
      end else begin
        dataPinOut <= config_q[wakeup_pkg::CFG_DOUT] &&
                      (rxData ^ config_q[wakeup_pkg::CFG_INVERT]);
        dataPinOe  <= 1'b1;
      end
      blockPowerDown    <= blockPd_q;
      clockDividerSetup <= divider_ratio_q;
      crystalSetup      <= xtal_q[0] ? xtal_q : (xtal_q & 8'h01);
      converterSource   <= level_q[6];
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  reset_slave_a: assert property (@(posedge clk_sys) $rose(rst_n) |->
    mode == wakeup_pkg::MODE_SLAVE) else $error("not slave after reset");
  slave_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == wakeup_pkg::MODE_SLAVE |=> !powerdownWakePinOe) else $error("pulse in slave");
  poll_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    config_q[1] |-> mode == wakeup_pkg::MODE_POLL) else $error("mode decode");
  timer_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == wakeup_pkg::MODE_TIMER && cycleEnd |=> pulseCnt_q != 16'h0000)
    else $error("timer pulse missing");
  valid_window_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    valid |-> gateTime > thLow_q[11:0] && levelIn.level > level_q[5:0])
    else $error("valid without window");
  status_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gateDone |=> $stable(status_q)) else $error("status changed");
  adc_echo_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> adc_q[5:0] == $past(levelIn.level)) else $error("adc echo");
  th_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    thUp_q[15:12] == 4'h0 && thLow_q[15:12] == 4'h0) else $error("threshold width");

endmodule

// ==== sim/mcu_model.sv ====
// Purpose: host controller side of the wake pin
// Assumes: pin pulled up, device only drives it low
// Notes:   measures low pulses in clock cycles
`timescale 1ns/1ps
module mcu_model (
  input  wire logic clk_sys,
  input  wire logic dutOut,
  input  wire logic dutOe,
  output logic      pinLevel,
  output int        pulses,
  output int        lowLen,
  output int        gap
);
  int cyc;   // free cycle count
  int run;   // current low length
  int fall;  // cycle of last falling edge
  initial {cyc, run, fall, pulses, lowLen, gap} = '0;
  // host leaves the pin to its pull-up, device may pull low
  assign pinLevel = dutOe ? dutOut : 1'b1;
  // ---------------------------------------------------------------
  // pulse length and spacing
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    run <= pinLevel ? 0 : run + 1;
    if (!pinLevel && run == 0) begin
      pulses <= pulses + 1;
      gap <= cyc - fall;
      fall <= cyc;
    end
    if (pinLevel && run != 0) lowLen <= run;
  end
endmodule

// ==== sim/wakeup_and_data_valid_logic_bench.sv ====
// Purpose: self-checking bench for the wake-up and data-valid block
// Assumes: short tick and pulse parameters, zero wait apb slave
// Notes:   lfsr stimulus from a fixed start, corners mixed in
`timescale 1ns/1ps
module wakeup_and_data_valid_logic_bench;
  localparam int TK = 4;  // tick cycles
  localparam int PL = 5;  // pulse cycles
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, gateDone = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, r = 32'h00EBD88C;
  logic pready, pslverr, powerdownWakePinOut, powerdownWakePinOe, dataPinOut, dataPinOe;
  logic clkOut, receiverOn, converterSource, pinLevel, err;
  logic [15:0] blockPowerDown;
  logic [7:0] clockDividerSetup, crystalSetup;
  wakeup_pkg::level_in_t levelIn = '0;
  logic [11:0] gateTime = '0, lo, up, g;
  logic [5:0] th;
  int n_mismatch = 0, checked = 0, n, p0, pulses, lowLen, gap;
  always #2 clk_sys = ~clk_sys;
  wakeup_and_data_valid_logic #(.TICK_CYCLES(TK), .PULSE_CYCLES(PL), .SETTLE_CYCLES(20)) DUT (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .levelIn, .gateTime, .gateDone, .ratePeriod(16'h0008),
    .powerdownWakePinIn(pinLevel), .internalDirection(1'b0), .transmitOn(1'b0),
    .rxData(gateTime[0]), .clkSource(clk_sys), .powerdownWakePinOut, .powerdownWakePinOe,
    .dataPinOut, .dataPinOe, .clkOut, .receiverOn, .blockPowerDown, .clockDividerSetup,
    .crystalSetup, .converterSource);
  mcu_model host (.clk_sys, .dutOut(powerdownWakePinOut), .dutOe(powerdownWakePinOe),
    .pinLevel, .pulses, .lowLen, .gap);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] sexp(input logic [11:0] v, a, b, input logic [5:0] l, t);
    sexp = {24'h0, v < a, v > a && v < b, v > b, v < a / 2, v > a / 2 && v < b / 2,
            v > b / 2, l == t, l > t};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bail(input logic ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    bail(k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic wrchk(input logic [7:0] idx, input logic [31:0] m);
    r = lfsr(lfsr(r));
    apb(1, idx, r);
    apb(0, idx, 0);
    chk(rd, r & m);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    chk({blockPowerDown, clockDividerSetup, crystalSetup}, 32'hFFFF0801);
    chk(converterSource, 1);
    for (n = 0; n < 7; n++) begin
      apb(0, n == 0 ? 8'h00 : n == 1 ? 8'h06 : n == 2 ? 8'h07 : n == 3 ? 8'h08
             : n == 4 ? 8'h0D : n == 5 ? 8'h0E : 8'h0F, 0);
      chk(rd, n == 0 ? 32'h0079 : n < 3 ? 0 : n == 3 ? 32'hFF : n == 4 ? 32'h08
             : n == 5 ? 32'h01 : 32'hFFFF);
    end
    apb(0, 8'h03, 0);
    chk(rd, 0);
    chk(err, 1);
    chk({dataPinOe, dataPinOut}, 2'b10);
    $display("test reset and map done");
    wrchk(8'h07, 32'h0FFF);
    wrchk(8'h06, 32'h0FFF);
    wrchk(8'h0D, 32'h003F);
    chk(clockDividerSetup, r[5:0]);
    wrchk(8'h0E, 32'h0007);
    chk(crystalSetup, r[0] ? r[2:0] : 3'h0);
    wrchk(8'h0F, 32'hFFFF);
    chk(blockPowerDown, r[15:0]);
    wrchk(8'h04, 32'hFFFF);
    $display("test masks done");
    for (n = 0; n < 8; n++) begin
      r = lfsr(lfsr(lfsr(r)));
      lo = 12'h200 + r[7:0];
      up = 12'h800 + r[15:8];
      th = r[21:16];
      g = n == 0 ? lo : n == 1 ? up : n == 2 ? lo / 2 : r[31:20];
      apb(1, 8'h06, lo);
      apb(1, 8'h07, up);
      apb(1, 8'h08, {25'h0, r[22], th});
      levelIn <= {n == 3 ? th : r[29:24], r[30], r[31]};
      gateTime <= g;
      gateDone <= 1;
      @(posedge clk_sys);
      gateDone <= 0;
      repeat (2) @(posedge clk_sys);
      chk(converterSource, r[22]);
      apb(0, 8'h80, 0);
      chk(rd, sexp(g, lo, up, levelIn.level, th));
      apb(1, 8'h81, 32'hFF);
      apb(0, 8'h81, 0);
      chk(rd, {24'h0, levelIn.adcOff, levelIn.source, levelIn.level});
    end
    $display("test status done");
    apb(1, 8'h04, 2);
    apb(1, 8'h05, 3);
    apb(1, 8'h00, 32'h007D);
    for (n = 0; n < 300 && pulses < 3; n++) @(posedge clk_sys);
    bail(pulses >= 3);
    chk(gap, 5 * TK);
    chk(lowLen, PL);
    chk(receiverOn, 0);
    apb(1, 8'h00, 32'h0079);
    repeat (10) @(posedge clk_sys);
    p0 = pulses;
    repeat (100) @(posedge clk_sys);
    chk(pulses, p0);
    $display("test timer done");
    apb(1, 8'h04, 40);
    apb(1, 8'h06, 16);
    apb(1, 8'h07, 64);
    apb(1, 8'h08, 32'h10);
    levelIn <= {6'h20, 2'b01};
    gateTime <= 12'h020;
    p0 = pulses;
    apb(1, 8'h00, 32'h001F);
    for (n = 0; n < 100 && receiverOn !== 1'b1; n++) @(posedge clk_sys);
    chk(receiverOn, 1);
    chk(clkOut, 1);
    for (n = 0; n < 200 && pulses == p0; n++) @(posedge clk_sys);
    chk(n > 40 && n < 54, 1);
    repeat (10) @(posedge clk_sys);
    chk(lowLen, PL);
    chk(pulses, p0 + 1);
    p0 = pulses;
    apb(1, 8'h00, 32'h007F);
    for (n = 0; n < 300 && pulses < p0 + 2; n++) begin
      gateDone <= n[4];
      @(posedge clk_sys);
    end
    gateDone <= 0;
    chk(pulses, p0 + 2);
    $display("test polling done");
    report_and_stop();
  end
endmodule
